// ---- hdl/asc_config_memory.sv ----
// Configuration store, working copy and quadrature pulse generation
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Memory reachable only in user mode
// - Diagnostic-disable word lives at location 0x09
// - Once locked, every write is refused
// - Working copy loaded at power-up, normal entry
// - Two 12-bit ID words, default zero
// - Zero point in 1/4096 turn steps
// - Zero point shifts quadrature and commutation angle
// - Quadrature word field positions D9 to D0
// - Direction bit: 0 CCW, 1 CW increasing
// - Index: pulse at zero, or half-turn switch
// - Enable bit 0 floats A, B, index
// - Hysteresis code decode, default one LSB
// - Code 0 follows every angle change
// - Zero LSB masks single-count dither
// - Resolution code selects pulses per turn
// - Lock value 3 open, else locked until reset
// - Scale angle; A, B, index from bits
module asc_config_memory (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Mode: high while in user mode
    input wire logic user_mode_i,
    // Register port
    input wire asc_pkg::asc_bus_req_s bus_i,
    output logic [asc_pkg::DATA_W-1:0] rdata_o,
    // Angle from the tracking loop
    input wire logic [11:0] angle_i,
    // Quadrature pins, driven while quad_oe_o is high
    output asc_pkg::asc_quad_s quad_o,
    output logic quad_oe_o,
    // Working settings for neighbouring blocks
    output logic [11:0] commut_angle_o,
    output logic [11:0] commut_cfg_o,
    output logic [asc_pkg::DIAG_W-1:0] diag_disable_o,
    output logic locked_o
);

    typedef logic [asc_pkg::NUM_WORDS-1:0][asc_pkg::DATA_W-1:0] asc_words_t;

    typedef struct packed {
        asc_pkg::asc_state_e st;
        logic mode_q;
        asc_words_t nvm;
        asc_words_t work;
        logic [11:0] filt;
        logic [11:0] adj;
        asc_pkg::asc_quad_s quad;
        logic oe;
        logic [asc_pkg::DATA_W-1:0] rdata;
    } asc_core_s;

    localparam asc_words_t NVM_DEFAULT = {
        asc_pkg::RST_COMMUT_CFG,
        asc_pkg::RST_DIAG_DIS,
        asc_pkg::RST_LOCK,
        asc_pkg::RST_QUAD_CFG,
        asc_pkg::RST_ZERO_POINT,
        asc_pkg::RST_IDENT,
        asc_pkg::RST_IDENT
    };

    localparam asc_core_s CORE_RESET = '{
        st: asc_pkg::ST_LOAD,
        mode_q: 1'b0,
        nvm: NVM_DEFAULT,
        work: NVM_DEFAULT,
        filt: 12'h000,
        adj: 12'h000,
        quad: '0,
        oe: 1'b0,
        rdata: 12'h000
    };

    asc_core_s q;
    asc_core_s d;

    logic mapped;
    logic [asc_pkg::IDX_W-1:0] idx;
    logic locked;
    logic reload;
    logic [11:0] qcfg;
    logic [2:0] hys;
    logic [asc_pkg::QC_RES_W-1:0] res;
    logic [11:0] rel;
    logic [11:0] adj;
    logic [11:0] diff;
    logic [11:0] mag;
    logic [11:0] band;
    logic [11:0] next_filt;
    logic [asc_pkg::PROD_W-1:0] prod;
    logic [11:0] scaled;

    always_comb begin
        mapped = (bus_i.addr >= asc_pkg::OFS_IDENT_ONE) &&
                 (bus_i.addr <= asc_pkg::OFS_COMMUT_CFG);
        idx = asc_pkg::IDX_W'(bus_i.addr - asc_pkg::OFS_IDENT_ONE);
        // Lock state read straight from the stored word
        locked = q.nvm[asc_pkg::IDX_LOCK][asc_pkg::LOCK_W-1:0] !=
                 asc_pkg::LOCK_OPEN;
        // Leaving user mode copies the store into the working set
        reload = (q.st == asc_pkg::ST_LOAD) ||
                 (q.mode_q && !user_mode_i);
        qcfg = q.work[asc_pkg::IDX_QUAD_CFG];
        hys = qcfg[asc_pkg::QC_HYS_LSB +: asc_pkg::QC_HYS_W];
        res = qcfg[asc_pkg::QC_RES_LSB +: asc_pkg::QC_RES_W];

        // Zero point first, then the sense of rotation
        rel = angle_i - q.work[asc_pkg::IDX_ZERO_POINT];
        adj = qcfg[asc_pkg::QC_DIR_BIT] ? 12'h000 - rel : rel;

        diff = q.adj - q.filt;
        mag = diff[11] ? 12'h000 - diff : diff;
        case (hys)
            asc_pkg::HYS_ZERO: band = asc_pkg::BAND_ZERO;
            asc_pkg::HYS_TWO: band = asc_pkg::BAND_TWO;
            asc_pkg::HYS_THREE: band = asc_pkg::BAND_THREE;
            default: band = asc_pkg::BAND_ONE;
        endcase
        // Move the held angle once the change clears the band; with hysteresis off, on every change
        if (hys == asc_pkg::HYS_OFF) begin
            next_filt = q.adj;
        end else if (mag >= band) begin
            next_filt = q.adj;
        end else begin
            next_filt = q.filt;
        end

        prod = asc_pkg::PROD_W'(q.filt) *
               asc_pkg::PROD_W'(asc_pkg::ppr_of(res));
        scaled = prod[asc_pkg::SCALE_SHIFT +: 12];

        d = q;
        d.mode_q = user_mode_i;
        d.adj = adj;
        d.filt = next_filt;
        d.rdata = 12'h000;

        // Writes reach the store only in user mode and while open
        if (bus_i.wr && mapped && user_mode_i && !locked) begin
            d.nvm[idx] = bus_i.wdata;
        end
        if (bus_i.rd && mapped && user_mode_i) begin
            d.rdata = q.nvm[idx];
        end

        case (q.st)
            asc_pkg::ST_LOAD: d.st = asc_pkg::ST_RUN;
            asc_pkg::ST_RUN: d.st = asc_pkg::ST_RUN;
            default: d.st = asc_pkg::ST_LOAD;
        endcase
        if (reload) begin
            d.work = q.nvm;
        end

        d.quad.a = scaled[1];
        d.quad.b = scaled[1] ^ scaled[0];
        if (qcfg[asc_pkg::QC_INDEX_FORM_BIT]) begin
            d.quad.index = q.filt < asc_pkg::HALF_TURN;
        end else begin
            d.quad.index = ~|scaled;
        end
        // Pins float until the first load has set the enable bit
        d.oe = qcfg[asc_pkg::QC_ENABLE_BIT] &&
               (q.st == asc_pkg::ST_RUN);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            q <= CORE_RESET;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign quad_o = q.quad;
    assign quad_oe_o = q.oe;
    assign commut_angle_o = q.adj;
    assign commut_cfg_o = q.work[asc_pkg::IDX_COMMUT_CFG];
    assign diag_disable_o =
        q.work[asc_pkg::IDX_DIAG_DIS][asc_pkg::DIAG_W-1:0];
    assign locked_o = locked;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    normal_read_zero_a: assert property (
        bus_i.rd && !user_mode_i |=> rdata_o == 12'h000)
        else $error("read in normal mode returned data");

    normal_write_drop_a: assert property (
        bus_i.wr && !user_mode_i |=> $stable(q.nvm))
        else $error("write in normal mode changed memory");

    locked_write_drop_a: assert property (
        locked && bus_i.wr |=> $stable(q.nvm))
        else $error("write changed locked memory");

    lock_sticky_a: assert property (
        locked |=> locked ##1 locked)
        else $error("memory lock released");

    ident_write_a: assert property (
        bus_i.wr && user_mode_i && !locked &&
        bus_i.addr == asc_pkg::OFS_IDENT_TWO
        ##1 bus_i.rd && user_mode_i &&
        bus_i.addr == asc_pkg::OFS_IDENT_TWO
        |=> rdata_o == $past(bus_i.wdata, 2))
        else $error("ident word read back wrong");

    reload_copy_a: assert property (
        $fell(user_mode_i) |=> q.work == $past(q.nvm))
        else $error("working set not reloaded");

    no_filter_a: assert property (
        hys == asc_pkg::HYS_OFF ##1 hys == asc_pkg::HYS_OFF
        |-> q.filt == $past(q.adj))
        else $error("unfiltered angle lagging");

    dither_mask_a: assert property (
        hys == asc_pkg::HYS_ZERO && mag == 12'h001 |=> $stable(q.filt))
        else $error("single count dither passed");

    index_pulse_a: assert property (
        !qcfg[asc_pkg::QC_INDEX_FORM_BIT] && !reload ##1 quad_o.index
        |-> !quad_o.a && !quad_o.b)
        else $error("index pulse away from zero state");

    output_float_a: assert property (
        !qcfg[asc_pkg::QC_ENABLE_BIT] && !reload |=> !quad_oe_o)
        else $error("pins driven while disabled");

    // Register port
    idle_read_zero_a: assert property (
        !bus_i.rd |=> rdata_o == 12'h000)
        else $error("read data outside the answer cycle");

    user_read_a: assert property (
        bus_i.rd && user_mode_i && mapped
        |=> rdata_o == $past(q.nvm[idx]))
        else $error("user read returned wrong word");

    unmapped_read_a: assert property (
        bus_i.rd && !mapped |=> rdata_o == 12'h000)
        else $error("unmapped read returned data");

    unmapped_write_a: assert property (
        bus_i.wr && !mapped |=> $stable(q.nvm))
        else $error("unmapped write changed memory");

    write_land_a: assert property (
        bus_i.wr && mapped && user_mode_i && !locked
        |=> q.nvm[$past(idx)] == $past(bus_i.wdata))
        else $error("open user write not stored");

    diag_write_a: assert property (
        bus_i.wr && user_mode_i && !locked &&
        bus_i.addr == asc_pkg::OFS_DIAG_DIS
        |=> q.nvm[asc_pkg::IDX_DIAG_DIS] == $past(bus_i.wdata))
        else $error("diagnostic word not at its location");

    // The lock word itself is stored, so the refusal starts next cycle
    lock_set_a: assert property (
        bus_i.wr && user_mode_i && !locked &&
        bus_i.addr == asc_pkg::OFS_LOCK &&
        bus_i.wdata[asc_pkg::LOCK_W-1:0] != asc_pkg::LOCK_OPEN
        |=> locked)
        else $error("lock write left memory open");

    // Working set
    load_to_run_a: assert property (
        q.st == asc_pkg::ST_LOAD |=> q.st == asc_pkg::ST_RUN)
        else $error("power-up load did not finish");

    load_copy_a: assert property (
        q.st == asc_pkg::ST_LOAD |=> q.work == $past(q.nvm))
        else $error("power-up load missed the store");

    user_hold_a: assert property (
        user_mode_i && q.st == asc_pkg::ST_RUN |=> $stable(q.work))
        else $error("working set moved in user mode");

    normal_hold_a: assert property (
        !user_mode_i && !$past(user_mode_i) &&
        q.st == asc_pkg::ST_RUN |=> $stable(q.work))
        else $error("working set moved in normal mode");

    load_float_a: assert property (
        q.st == asc_pkg::ST_LOAD |=> !quad_oe_o)
        else $error("pins driven before the first load");

    enable_drive_a: assert property (
        qcfg[asc_pkg::QC_ENABLE_BIT] && q.st == asc_pkg::ST_RUN
        |=> quad_oe_o)
        else $error("enabled pins left floating");

    // Angle path; the reverse sense is checked as a sum so it does not mirror the logic
    ccw_offset_a: assert property (
        !qcfg[asc_pkg::QC_DIR_BIT]
        |=> commut_angle_o == 12'($past(angle_i) -
            $past(q.work[asc_pkg::IDX_ZERO_POINT])))
        else $error("zero point not taken off the angle");

    cw_offset_a: assert property (
        qcfg[asc_pkg::QC_DIR_BIT]
        |=> 12'(commut_angle_o + $past(angle_i)) ==
            $past(q.work[asc_pkg::IDX_ZERO_POINT]))
        else $error("reverse sense not applied");

    dither_any_a: assert property (
        hys != asc_pkg::HYS_OFF && mag == 12'h001 |=> $stable(q.filt))
        else $error("one-count dither passed a filter");

    jump_follow_a: assert property (
        hys != asc_pkg::HYS_OFF && mag >= asc_pkg::BAND_THREE
        |=> q.filt == $past(q.adj))
        else $error("filter held past the widest band");

    // Pin generation for the 1024, 512 and 256 pulse resolutions
    full_res_pins_a: assert property (
        res == 4'h0
        |=> quad_o.a == $past(q.filt[1]) &&
            quad_o.b == $past(q.filt[1] ^ q.filt[0]))
        else $error("pins wrong at full resolution");

    half_res_pins_a: assert property (
        res == 4'h1
        |=> quad_o.a == $past(q.filt[2]) &&
            quad_o.b == $past(q.filt[2] ^ q.filt[1]))
        else $error("pins wrong at half resolution");

    quarter_res_pins_a: assert property (
        res == 4'h2
        |=> quad_o.a == $past(q.filt[3]) &&
            quad_o.b == $past(q.filt[3] ^ q.filt[2]))
        else $error("pins wrong at quarter resolution");

    switch_index_a: assert property (
        qcfg[asc_pkg::QC_INDEX_FORM_BIT]
        |=> quad_o.index == !$past(q.filt[11]))
        else $error("switch index not split at half turn");

    zero_index_a: assert property (
        !qcfg[asc_pkg::QC_INDEX_FORM_BIT] && res == 4'h0
        |=> quad_o.index == ($past(q.filt) == 12'h000))
        else $error("index pulse away from zero");

    // Main scenarios
    lock_event_c: cover property (!locked ##1 locked);
    mode_reload_c: cover property (
        $fell(user_mode_i) ##1 q.st == asc_pkg::ST_RUN);
    switch_index_c: cover property (
        qcfg[asc_pkg::QC_INDEX_FORM_BIT] && quad_o.index);
    dither_hold_c: cover property (
        hys == asc_pkg::HYS_ZERO && mag == 12'h001);
    locked_refuse_c: cover property (locked && bus_i.wr && user_mode_i);

endmodule // asc_config_memory

`default_nettype wire

// ---- hdl/asc_pkg.sv ----
// Package: constants, types and lookup helpers of the configuration store
package asc_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 12;
    localparam int NUM_WORDS = 7;
    localparam int IDX_W = 3;

    // Word offsets on the register port
    localparam logic [3:0] OFS_IDENT_ONE = 4'h4;
    localparam logic [3:0] OFS_IDENT_TWO = 4'h5;
    localparam logic [3:0] OFS_ZERO_POINT = 4'h6;
    localparam logic [3:0] OFS_QUAD_CFG = 4'h7;
    localparam logic [3:0] OFS_LOCK = 4'h8;
    localparam logic [3:0] OFS_DIAG_DIS = 4'h9;
    localparam logic [3:0] OFS_COMMUT_CFG = 4'ha;

    // Array slots, counted from the first mapped offset
    localparam logic [2:0] IDX_IDENT_ONE = 3'h0;
    localparam logic [2:0] IDX_IDENT_TWO = 3'h1;
    localparam logic [2:0] IDX_ZERO_POINT = 3'h2;
    localparam logic [2:0] IDX_QUAD_CFG = 3'h3;
    localparam logic [2:0] IDX_LOCK = 3'h4;
    localparam logic [2:0] IDX_DIAG_DIS = 3'h5;
    localparam logic [2:0] IDX_COMMUT_CFG = 3'h6;

    // Factory contents of each word
    localparam logic [11:0] RST_IDENT = 12'h000;
    localparam logic [11:0] RST_ZERO_POINT = 12'h000;
    localparam logic [11:0] RST_QUAD_CFG = 12'h0a0;
    localparam logic [11:0] RST_LOCK = 12'h003;
    localparam logic [11:0] RST_DIAG_DIS = 12'h000;
    localparam logic [11:0] RST_COMMUT_CFG = 12'h052;

    // Fields of the quadrature configuration word
    localparam int QC_DIR_BIT = 9;
    localparam int QC_INDEX_FORM_BIT = 8;
    localparam int QC_ENABLE_BIT = 7;
    localparam int QC_HYS_LSB = 4;
    localparam int QC_HYS_W = 3;
    localparam int QC_RES_LSB = 0;
    localparam int QC_RES_W = 4;

    // Lock field
    localparam int LOCK_W = 2;
    localparam logic [1:0] LOCK_OPEN = 2'h3;

    // Diagnostic-disable field width
    localparam int DIAG_W = 2;

    // Hysteresis codes with their own meaning; the rest act as one LSB
    localparam logic [2:0] HYS_OFF = 3'h0;
    localparam logic [2:0] HYS_ZERO = 3'h1;
    localparam logic [2:0] HYS_TWO = 3'h3;
    localparam logic [2:0] HYS_THREE = 3'h4;
    localparam logic [11:0] BAND_ZERO = 12'h002;
    localparam logic [11:0] BAND_ONE = 12'h003;
    localparam logic [11:0] BAND_TWO = 12'h004;
    localparam logic [11:0] BAND_THREE = 12'h005;

    // Scaling: angle * ppr * 4 / 4096 keeps bits above this shift
    localparam int PROD_W = 23;
    localparam int SCALE_SHIFT = 10;
    localparam logic [11:0] HALF_TURN = 12'h800;

    typedef enum logic {
        ST_LOAD,
        ST_RUN
    } asc_state_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } asc_bus_req_s;

    typedef struct packed {
        logic a;
        logic b;
        logic index;
    } asc_quad_s;

    // Pulses per revolution for each resolution code
    function automatic logic [10:0] ppr_of(input logic [3:0] code);
        case (code)
            4'h0: ppr_of = 11'h400;
            4'h1: ppr_of = 11'h200;
            4'h2: ppr_of = 11'h100;
            4'h3: ppr_of = 11'h080;
            4'h4: ppr_of = 11'h3e8;
            4'h5: ppr_of = 11'h384;
            4'h6: ppr_of = 11'h320;
            4'h7: ppr_of = 11'h2bc;
            4'h8: ppr_of = 11'h258;
            4'h9: ppr_of = 11'h1f4;
            4'ha: ppr_of = 11'h190;
            4'hb: ppr_of = 11'h168;
            4'hc: ppr_of = 11'h12c;
            4'hd: ppr_of = 11'h0c8;
            4'he: ppr_of = 11'h064;
            default: ppr_of = 11'h032;
        endcase
    endfunction

endpackage

// ---- verification/asc_host_model.sv ----
// Host model that programs the configuration store over the register port
`timescale 1ns/10ps
`default_nettype none

module asc_host_model (
    // Clock
    input wire logic clk_i,
    // Register port
    output var asc_pkg::asc_bus_req_s bus_o,
    input wire logic [asc_pkg::DATA_W-1:0] rdata_i,
    // Mode control
    output var logic user_mode_o
);
    initial begin
        bus_o = '0;
        user_mode_o = 1'b0;
    end

    // Released address and data are inverted so stale values never match
    task automatic write_word(input logic [3:0] addr, input logic [11:0] data);
        @(posedge clk_i);
        bus_o <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_o <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic read_word(input logic [3:0] addr, output logic [11:0] data);
        @(posedge clk_i);
        bus_o <= '{addr: addr, wdata: ~bus_o.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_o <= '{addr: ~addr, wdata: bus_o.wdata, wr: 1'b0, rd: 1'b0};
        #1 data = rdata_i;
    endtask

    // Write and read of one word with no idle cycle between them
    task automatic write_read(input logic [3:0] addr, input logic [11:0] data,
            output logic [11:0] back);
        @(posedge clk_i);
        bus_o <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus_o <= '{addr: addr, wdata: ~data, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus_o <= '{addr: ~addr, wdata: data, wr: 1'b0, rd: 1'b0};
        #1 back = rdata_i;
    endtask

    // Dropping back to normal mode is what applies new settings
    task automatic set_mode(input logic user);
        @(posedge clk_i);
        user_mode_o <= user;
    endtask
endmodule // asc_host_model

`default_nettype wire

// ---- verification/asc_testbench.sv ----
// Self-checking testbench of the configuration store
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic clk_i, rst_b_i, user_mode_i, quad_oe_o, locked_o;
    logic [11:0] angle_i, rdata_o, commut_angle_o, commut_cfg_o, rv;
    logic [1:0] diag_disable_o;
    asc_pkg::asc_bus_req_s bus_i;
    asc_pkg::asc_quad_s quad_o;
    int n_fail, tests_run;
    int ppr_tab[16] = '{1024, 512, 256, 128, 1000, 900, 800, 700, 600, 500,
        400, 360, 300, 200, 100, 50};
    int band_tab[8] = '{1, 2, 3, 4, 5, 3, 3, 3};
    logic [11:0] def_tab[7] = '{12'h000, 12'h000, 12'h000, 12'h0a0, 12'h003,
        12'h000, 12'h052};

    asc_config_memory uut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .user_mode_i(user_mode_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .angle_i(angle_i), .quad_o(quad_o), .quad_oe_o(quad_oe_o),
        .commut_angle_o(commut_angle_o), .commut_cfg_o(commut_cfg_o),
        .diag_disable_o(diag_disable_o), .locked_o(locked_o));
    asc_host_model host (.clk_i(clk_i), .bus_o(bus_i), .rdata_i(rdata_o),
        .user_mode_o(user_mode_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check_word(input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // Compares {enable, A, B, index}
    task automatic check_pins(input logic [3:0] exp);
        tests_run++;
        if ({quad_oe_o, quad_o} !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp,
                {quad_oe_o, quad_o});
        end
    endtask

    function automatic logic [3:0] exp_pins(input int d, input int ppr,
            input logic sw);
        logic [11:0] s;
        s = 12'((d * ppr * 4) / 4096);
        return {1'b1, s[1], s[1] ^ s[0], sw ? (d < 2048) : (s == 12'h000)};
    endfunction

    function automatic logic [11:0] qcfg(input logic dir, input logic sw,
            input logic en, input logic [2:0] hys, input logic [3:0] res);
        return {2'h0, dir, sw, en, hys, res};
    endfunction

    task automatic settle();
        repeat (8) @(posedge clk_i);
        #1;
    endtask

    task automatic put(input int d);
        @(posedge clk_i);
        angle_i <= 12'(12'h100 + d);
        settle();
    endtask

    task automatic apply(input logic [11:0] c);
        host.set_mode(1'b1);
        host.write_word(4'h7, c);
        host.set_mode(1'b0);
        settle();
    endtask

    // Cuts a hang short
    initial begin
        repeat (100000) @(posedge clk_i);
        n_fail++;
        give_verdict();
    end

    initial begin
        n_fail = 0;
        tests_run = 0;
        angle_i = 12'h000;
        rst_b_i = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        settle();
        check_pins(4'h9);
        check_word(12'h052, commut_cfg_o);
        check_word(12'h000, {9'h0, diag_disable_o, locked_o});
        host.write_word(4'h4, 12'h5a5);
        host.read_word(4'h4, rv);
        check_word(12'h000, rv);
        host.set_mode(1'b1);
        for (int i = 0; i < 7; i++) begin
            host.read_word(4'(4 + i), rv);
            check_word(def_tab[i], rv);
        end
        host.read_word(4'h3, rv);
        check_word(12'h000, rv);
        host.read_word(4'hb, rv);
        check_word(12'h000, rv);
        host.write_word(4'h4, 12'hfff);
        host.write_read(4'h5, 12'h123, rv);
        check_word(12'h123, rv);
        host.read_word(4'h4, rv);
        check_word(12'hfff, rv);
        host.write_word(4'h9, 12'h003);
        host.write_word(4'h6, 12'h100);
        host.write_word(4'h7, qcfg(1'b0, 1'b0, 1'b0, 3'h0, 4'h0));
        settle();
        check_word(12'h001, {11'h0, quad_oe_o});
        host.set_mode(1'b0);
        settle();
        check_word(12'h000, {11'h0, quad_oe_o});
        check_word(12'h003, {10'h0, diag_disable_o});
        apply(qcfg(1'b0, 1'b0, 1'b1, 3'h0, 4'h0));
        foreach (band_tab[i]) begin
            put(i);
            check_pins(exp_pins(i, 1024, 1'b0));
            check_word(12'(i), commut_angle_o);
        end
        for (int c = 0; c < 16; c++) begin
            apply(qcfg(1'b0, 1'b0, 1'b1, 3'h0, 4'(c)));
            put(12'h123);
            check_pins(exp_pins(12'h123, ppr_tab[c], 1'b0));
        end
        apply(qcfg(1'b1, 1'b0, 1'b1, 3'h0, 4'h0));
        put(5);
        check_word(12'hffb, commut_angle_o);
        check_pins(exp_pins(12'hffb, 1024, 1'b0));
        apply(qcfg(1'b0, 1'b1, 1'b1, 3'h0, 4'h0));
        put(12'h7ff);
        check_pins(exp_pins(12'h7ff, 1024, 1'b1));
        put(12'h801);
        check_pins(exp_pins(12'h801, 1024, 1'b1));
        for (int h = 1; h < 8; h++) begin
            // Switch index at the half turn shows which side filt is on
            apply(qcfg(1'b0, 1'b1, 1'b1, 3'(h), 4'h0));
            put(12'h400);
            put(12'h800);
            put(12'h800 - band_tab[h] + 1);
            check_pins(exp_pins(12'h800, 1024, 1'b1));
            put(12'h800 - band_tab[h]);
            check_pins(exp_pins(12'h800 - band_tab[h], 1024, 1'b1));
        end
        host.set_mode(1'b1);
        host.write_word(4'h8, 12'h001);
        settle();
        check_word(12'h001, {11'h0, locked_o});
        host.write_word(4'h4, 12'h0aa);
        host.write_word(4'h8, 12'h003);
        host.read_word(4'h4, rv);
        check_word(12'hfff, rv);
        host.read_word(4'h8, rv);
        check_word(12'h001, rv);
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
